/* shared/csot_consts.vh */
/*
 Constants of the clock select and oscillator trim block: register indices,
 field positions, reset values, encodings and divider figures.
 Assumes it is included by bare name; holds definitions only.
*/
`ifndef CSOT_CONSTS_VH
`define CSOT_CONSTS_VH

// Register indices; byte address is four times the index
`define CSOT_IDX_TMR_CFG 10'h031
`define CSOT_IDX_FAST_TRIM 10'h034
`define CSOT_IDX_SLOW_TRIM 10'h036
`define CSOT_IDX_USB_LOCK 10'h039
`define CSOT_IDX_ROUTE 10'h03a
`define CSOT_IDX_STATUS 10'h03b
`define CSOT_IDX_TBL_CMD 10'h03c
`define CSOT_IDX_PBLK 7'h1f
`define CSOT_IDX_OSC_CTRL 10'h1e0

// Reset values
`define CSOT_TMR_CFG_RST 8'h0c
`define CSOT_ROUTE_RST 8'h04
`define CSOT_OSC_CTRL_RST 8'h00

// Field positions
`define CSOT_SPD_F 2:0
`define CSOT_SLP_F 4:3
`define CSOT_ISEL_F 1:0
`define CSOT_IDIV_F 3:2
`define CSOT_CSEL_F 5:4
`define CSOT_CDIV_F 7:6
`define CSOT_LOCK_DIS_B 0
`define CSOT_FINE_ONLY_B 1
`define CSOT_OUT_SEL_F 1:0
`define CSOT_USB_DIV2_B 2
`define CSOT_EFT_EN_B 3
`define CSOT_LP_MODE_B 7
`define CSOT_BIAS_F 5:4
`define CSOT_SLOW_RW_MASK 8'hbf

// Encodings
`define CSOT_SRC_FAST 2'b00
`define CSOT_SRC_SLOW 2'b10
`define CSOT_SRC_TCAP 2'b11
`define CSOT_OUT_EXT 2'b00
`define CSOT_OUT_FAST 2'b01
`define CSOT_OUT_SLOW 2'b10
`define CSOT_OUT_CPU 2'b11
`define CSOT_BIAS_BAD 2'b10
`define CSOT_KEY_TBL 8'h3a
`define CSOT_OP_TBL 8'h06
`define CSOT_TBL_ID 3'h0

// Wakeup divisors on slow ticks (512, 64, 8, 1 Hz from 32768 Hz)
`define CSOT_WAKE_DIV0 16'h0040
`define CSOT_WAKE_DIV1 16'h0200
`define CSOT_WAKE_DIV2 16'h1000
`define CSOT_WAKE_DIV3 16'h8000

`endif

/* design/csot_sync.v */
/*
 Two-flop level synchroniser for one pin.
 Assumes the pin is asynchronous to pclk; only the second flop is read outside.
*/
`timescale 1ns/100ps
module csot_sync (
	input wire pclk, // Block clock
	input wire presetn, // Asynchronous reset, active low
	input wire pin_in, // Asynchronous level
	output wire sync_out // Synchronised level
);
	reg meta_ff;
	reg sync_ff;

	// Second flop only sees the first; nothing else taps it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end
	assign sync_out = sync_ff;
endmodule // csot_sync

/* design/csot_clkdiv.v */
/*
 Enable-pulse divider: one pulse for every div_val input ticks.
 Assumes tick_en is a one-cycle enable on pclk; div_val of zero acts as one.
*/
`timescale 1ns/100ps
module csot_clkdiv #(
	parameter W = 8
) (
	input wire pclk, // Block clock
	input wire presetn, // Asynchronous reset, active low
	input wire tick_en, // Source tick
	input wire [W-1:0] div_val, // Requested divisor
	output wire pulse // Divided tick, one cycle
);
	reg [W-1:0] cnt_ff;
	reg [W-1:0] cur_ff;
	reg pulse_ff;
	wire wrap;

	assign wrap = (cnt_ff + {{(W-1){1'b0}}, 1'b1} >= cur_ff);

	// New divisor only taken at a period boundary so no short period appears
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= {W{1'b0}};
			cur_ff <= {{(W-1){1'b0}}, 1'b1};
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= tick_en & wrap;
			if (tick_en) begin
				if (wrap) begin
					cnt_ff <= {W{1'b0}};
					cur_ff <= (div_val == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : div_val;
				end else begin
					cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
	assign pulse = pulse_ff;
endmodule // csot_clkdiv

/* design/csot_top.v */
/*
 Clock select and oscillator trim block with APB register access.
 Derived clocks are one-cycle enable pulses on pclk. Oscillator ticks,
 sleep and USB packet marks come from logic on pclk; the external clock
 input is a pin and is synchronised here.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "csot_consts.vh"
module csot_top #(
	parameter [15:0] CHIP_ID = 16'h5a5a, // Arbitrary identifier value
	parameter [15:0] TUNE_REF = 16'd1000, // Fast ticks expected between USB marks
	parameter [15:0] TUNE_TOL = 16'd15 // Allowed error, about 1.5 percent
) (
	input wire pclk, // 10 MHz bus clock
	input wire presetn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error for unmapped index
	input wire fast_osc_tick, // Fast oscillator tick
	input wire slow_osc_tick, // Slow oscillator tick
	input wire external_clock_input, // Clock pin, asynchronous
	input wire sleep, // Device in sleep
	input wire usb_mark, // USB packet timing mark from engine
	input wire boot_load, // Boot strobe to load factory trims
	input wire [7:0] factory_fast_trim, // Factory fast trim
	input wire [7:0] factory_slow_trim, // Factory slow trim
	output wire cpu_clock, // CPU clock enable
	output wire usb_engine_clock, // USB engine clock enable
	output wire interval_timer_clock, // Interval timer clock enable
	output wire capture_timer_clock, // Capture timer clock enable
	output wire clock_output_pin, // Clock output level
	output wire wakeup_tick, // Periodic wakeup pulse
	output wire [2:0] fast_offset, // Fine offset to oscillator
	output wire [4:0] fast_gain, // Gain to oscillator
	output wire [7:0] fast_tune, // USB retune correction
	output wire slow_low_power, // Slow oscillator mode
	output wire [1:0] slow_bias, // Slow oscillator bias
	output wire [3:0] slow_freq_trim // Slow oscillator frequency trim
);
	reg [7:0] fast_trim_ff;
	reg [7:0] slow_trim_ff;
	reg [7:0] osc_ctrl_ff;
	reg [7:0] tmr_cfg_ff;
	reg [7:0] usb_lock_ff;
	reg [7:0] route_ff;
	reg [7:0] pblk_ff [0:7];
	reg pready_ff;
	reg pslverr_ff;
	reg [31:0] prdata_ff;
	reg [31:0] nxt_rdata;
	reg nxt_hit;
	reg [2:0] cpu_exp_ff;
	reg [15:0] tune_cnt_ff;
	reg [7:0] tune_ff;
	reg tune_armed_ff;
	reg [15:0] wake_cnt_ff;
	reg wake_ff;
	reg eft_prev_ff;
	reg ext_lvl_ff;
	reg ext_tick_ff;
	reg out_ff;
	reg [1:0] out_sel_ff;
	reg itmr_src;
	reg tcap_src;
	reg out_src;
	reg [15:0] wake_div;
	integer i;
	wire [9:0] idx;
	wire access;
	wire wr_en;
	wire ext_sync;
	wire cpu_pulse;
	wire usb_pulse;
	wire itmr_pulse;
	wire tcap_pulse;
	wire slow_ok;
	wire [7:0] cpu_div;
	wire [3:0] spd_now;

	// APB decode: index is the word address
	assign idx = paddr[11:2];
	assign access = psel & penable;
	assign wr_en = access & pready_ff & pwrite & ~pslverr_ff;

	// CPU speed code to divider exponent; reserved code returns 4'h8 flag
	function [3:0] spd_exp;
		input [2:0] code;
		begin
			case (code)
				3'h0: spd_exp = 4'h3;
				3'h1: spd_exp = 4'h2;
				3'h2: spd_exp = 4'h1;
				3'h3: spd_exp = 4'h0;
				3'h4: spd_exp = 4'h4;
				3'h5: spd_exp = 4'h5;
				3'h6: spd_exp = 4'h7;
				default: spd_exp = 4'h8;
			endcase
		end
	endfunction

	// Index hit test, shared by decode and error answer
	function is_mapped;
		input [9:0] a;
		begin
			is_mapped = (a == `CSOT_IDX_TMR_CFG) || (a == `CSOT_IDX_FAST_TRIM) ||
				(a == `CSOT_IDX_SLOW_TRIM) || (a == `CSOT_IDX_USB_LOCK) ||
				(a == `CSOT_IDX_ROUTE) || (a == `CSOT_IDX_STATUS) ||
				(a == `CSOT_IDX_TBL_CMD) || (a == `CSOT_IDX_OSC_CTRL) ||
				(a[9:3] == `CSOT_IDX_PBLK);
		end
	endfunction

	// Read mux
	always @* begin
		nxt_rdata = 32'h0000_0000;
		nxt_hit = is_mapped(idx);
		case (idx)
			`CSOT_IDX_TMR_CFG: nxt_rdata[7:0] = tmr_cfg_ff;
			`CSOT_IDX_FAST_TRIM: nxt_rdata[7:0] = fast_trim_ff;
			`CSOT_IDX_SLOW_TRIM: nxt_rdata[7:0] = slow_trim_ff & `CSOT_SLOW_RW_MASK;
			`CSOT_IDX_USB_LOCK: nxt_rdata[7:0] = usb_lock_ff;
			`CSOT_IDX_ROUTE: nxt_rdata[7:0] = route_ff;
			`CSOT_IDX_STATUS: nxt_rdata[7:0] = tune_ff;
			`CSOT_IDX_OSC_CTRL: nxt_rdata[7:0] = osc_ctrl_ff;
			default: begin
				if (idx[9:3] == `CSOT_IDX_PBLK) begin
					nxt_rdata[7:0] = pblk_ff[idx[2:0]];
				end
			end
		endcase
	end

	// Bus handshake: one wait cycle, then ready with data or error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~nxt_hit;
			if (psel & penable & ~pready_ff & ~pwrite) begin
				prdata_ff <= nxt_rdata;
			end
		end
	end

	// Configuration registers; trims reset to zero until boot loads them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_trim_ff <= 8'h00;
			slow_trim_ff <= 8'h00;
			osc_ctrl_ff <= `CSOT_OSC_CTRL_RST;
			tmr_cfg_ff <= `CSOT_TMR_CFG_RST;
			usb_lock_ff <= 8'h00;
			route_ff <= `CSOT_ROUTE_RST;
		end else if (boot_load) begin
			fast_trim_ff <= factory_fast_trim;
			slow_trim_ff <= factory_slow_trim & `CSOT_SLOW_RW_MASK;
		end else if (wr_en) begin
			case (idx)
				`CSOT_IDX_FAST_TRIM: fast_trim_ff <= pwdata[7:0];
				`CSOT_IDX_SLOW_TRIM: begin
					slow_trim_ff[`CSOT_LP_MODE_B] <= pwdata[`CSOT_LP_MODE_B];
					slow_trim_ff[3:0] <= pwdata[3:0];
					// Bias code that may stop the oscillator is refused on bus writes; boot load does not filter it
					if (pwdata[`CSOT_BIAS_F] != `CSOT_BIAS_BAD) begin
						slow_trim_ff[`CSOT_BIAS_F] <= pwdata[`CSOT_BIAS_F];
					end
				end
				`CSOT_IDX_OSC_CTRL: begin
					osc_ctrl_ff[4:3] <= pwdata[4:3];
					// Reserved speed code leaves the clock as it was
					if (spd_exp(pwdata[2:0]) != 4'h8) begin
						osc_ctrl_ff[`CSOT_SPD_F] <= pwdata[2:0];
					end
				end
				`CSOT_IDX_TMR_CFG: tmr_cfg_ff <= pwdata[7:0];
				`CSOT_IDX_USB_LOCK: usb_lock_ff <= {6'h00, pwdata[1:0]};
				`CSOT_IDX_ROUTE: route_ff <= {4'h0, pwdata[3:0]};
				default: begin
				end
			endcase
		end
	end

	// Parameter block and table read command
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < 8; i = i + 1) begin
				pblk_ff[i] <= 8'h00;
			end
		end else if (wr_en && idx[9:3] == `CSOT_IDX_PBLK) begin
			pblk_ff[idx[2:0]] <= pwdata[7:0];
		end else if (wr_en && idx == `CSOT_IDX_TBL_CMD) begin
			// Needs key and opcode; only low three table bits count
			if (pwdata[7:0] == `CSOT_OP_TBL && pblk_ff[0] == `CSOT_KEY_TBL) begin
				if (pblk_ff[2][2:0] == `CSOT_TBL_ID) begin
					pblk_ff[0] <= CHIP_ID[15:8];
					pblk_ff[1] <= CHIP_ID[7:0];
				end
			end
		end
	end

	// CPU divider: exponent held while the code is reserved
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_exp_ff <= 3'h3;
		end else if (spd_now != 4'h8) begin
			cpu_exp_ff <= spd_now[2:0];
		end
	end
	assign spd_now = spd_exp(osc_ctrl_ff[`CSOT_SPD_F]);
	assign cpu_div = 8'h01 << cpu_exp_ff;

	csot_clkdiv #(.W(8)) u_cpu_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_en(fast_osc_tick),
		.div_val(cpu_div),
		.pulse(cpu_pulse)
	);

	csot_clkdiv #(.W(2)) u_usb_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_en(fast_osc_tick),
		.div_val(route_ff[`CSOT_USB_DIV2_B] ? 2'h2 : 2'h1),
		.pulse(usb_pulse)
	);

	// Slow source is withheld from timers and pin during sleep
	assign slow_ok = slow_osc_tick & ~sleep;

	// Source selection; reserved and disabled codes give no ticks
	always @* begin
		case (tmr_cfg_ff[`CSOT_CSEL_F])
			`CSOT_SRC_FAST: tcap_src = fast_osc_tick;
			`CSOT_SRC_SLOW: tcap_src = slow_ok;
			default: tcap_src = 1'b0;
		endcase
		case (tmr_cfg_ff[`CSOT_ISEL_F])
			`CSOT_SRC_FAST: itmr_src = fast_osc_tick;
			`CSOT_SRC_SLOW: itmr_src = slow_ok;
			`CSOT_SRC_TCAP: itmr_src = tcap_pulse;
			default: itmr_src = 1'b0;
		endcase
	end

	csot_clkdiv #(.W(4)) u_tcap_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_en(tcap_src),
		.div_val({1'b0, tmr_cfg_ff[`CSOT_CDIV_F], 1'b0} + 4'h2),
		.pulse(tcap_pulse)
	);

	csot_clkdiv #(.W(3)) u_itmr_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick_en(itmr_src),
		.div_val({1'b0, tmr_cfg_ff[`CSOT_IDIV_F]} + 3'h1),
		.pulse(itmr_pulse)
	);

	// External clock pin, then optional two-sample transient filter
	csot_sync u_ext_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(external_clock_input),
		.sync_out(ext_sync)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eft_prev_ff <= 1'b0;
			ext_lvl_ff <= 1'b0;
			ext_tick_ff <= 1'b0;
		end else begin
			eft_prev_ff <= ext_sync;
			ext_tick_ff <= 1'b0;
			// Filter trades one cycle of delay for rejecting single-sample spikes
			if (!route_ff[`CSOT_EFT_EN_B] || ext_sync == eft_prev_ff) begin
				ext_lvl_ff <= ext_sync;
				ext_tick_ff <= ext_sync & ~ext_lvl_ff;
			end
		end
	end

	// Output pin source; selection switches only while the pin is low
	always @* begin
		case (out_sel_ff)
			`CSOT_OUT_EXT: out_src = ext_tick_ff;
			`CSOT_OUT_FAST: out_src = fast_osc_tick;
			`CSOT_OUT_SLOW: out_src = slow_ok;
			`CSOT_OUT_CPU: out_src = cpu_pulse;
			default: out_src = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ff <= 1'b0;
			out_sel_ff <= `CSOT_OUT_EXT;
		end else begin
			if (out_src) begin
				out_ff <= ~out_ff;
			end
			if (!out_ff) begin // A source ticking every cycle must not pin the select
				out_sel_ff <= route_ff[`CSOT_OUT_SEL_F];
			end
		end
	end

	// Wakeup divisor chosen from the sleep timer field
	always @* begin
		case (osc_ctrl_ff[`CSOT_SLP_F])
			2'h0: wake_div = `CSOT_WAKE_DIV0;
			2'h1: wake_div = `CSOT_WAKE_DIV1;
			2'h2: wake_div = `CSOT_WAKE_DIV2;
			default: wake_div = `CSOT_WAKE_DIV3;
		endcase
	end

	// Slow ticks keep counting in sleep; the wakeup does not depend on the main clock gating
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cnt_ff <= 16'h0000;
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= 1'b0;
			if (slow_osc_tick) begin
				if (wake_cnt_ff + 16'h0001 >= wake_div) begin
					wake_cnt_ff <= 16'h0000;
					wake_ff <= 1'b1;
				end else begin
					wake_cnt_ff <= wake_cnt_ff + 16'h0001;
				end
			end
		end
	end

	// USB retune: count fast ticks between marks and nudge the correction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune_cnt_ff <= 16'h0000;
			tune_ff <= 8'h80;
			tune_armed_ff <= 1'b0;
		end else if (usb_lock_ff[`CSOT_LOCK_DIS_B]) begin
			tune_cnt_ff <= 16'h0000;
			tune_armed_ff <= 1'b0;
		end else if (usb_mark) begin
			tune_cnt_ff <= 16'h0000;
			tune_armed_ff <= 1'b1;
			// First mark only starts the count; each later mark steps by at most one
			if (tune_armed_ff) begin
				if (tune_cnt_ff > TUNE_REF + TUNE_TOL && tune_ff != 8'h00) begin
					tune_ff <= tune_ff - 8'h01;
				end else if (tune_cnt_ff + TUNE_TOL < TUNE_REF && tune_ff != 8'hff) begin
					tune_ff <= tune_ff + 8'h01;
				end
			end
		end else if (fast_osc_tick && tune_cnt_ff != 16'hffff) begin
			tune_cnt_ff <= tune_cnt_ff + 16'h0001;
		end
	end

	// Derived clock enables leave through one flop each
	reg cpu_o_ff;
	reg usb_o_ff;
	reg itmr_o_ff;
	reg tcap_o_ff;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_o_ff <= 1'b0;
			usb_o_ff <= 1'b0;
			itmr_o_ff <= 1'b0;
			tcap_o_ff <= 1'b0;
		end else begin
			cpu_o_ff <= cpu_pulse;
			usb_o_ff <= usb_pulse;
			itmr_o_ff <= itmr_pulse;
			tcap_o_ff <= tcap_pulse;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign cpu_clock = cpu_o_ff;
	assign usb_engine_clock = usb_o_ff;
	assign interval_timer_clock = itmr_o_ff;
	assign capture_timer_clock = tcap_o_ff;
	assign clock_output_pin = out_ff;
	assign wakeup_tick = wake_ff;
	assign fast_offset = fast_trim_ff[7:5];
	assign fast_gain = fast_trim_ff[4:0];
	assign fast_tune = tune_ff;
	assign slow_low_power = slow_trim_ff[`CSOT_LP_MODE_B];
	assign slow_bias = slow_trim_ff[`CSOT_BIAS_F];
	assign slow_freq_trim = slow_trim_ff[3:0];
endmodule // csot_top

/* bench/csot_chk.sv */
/*
 Checker for csot_top: APB wait timing, trim fields, enable sources, retune.
 Assumes it is bound to csot_top and that pclk is the only clock.
*/
`timescale 1ns/100ps
`include "csot_consts.vh"
module csot_chk (
	input wire pclk, // Block clock
	input wire presetn, // Reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB address
	input wire [31:0] pwdata, // APB write data
	input wire pready, // APB ready
	input wire pslverr, // APB error
	input wire fast_osc_tick, // Fast tick
	input wire slow_osc_tick, // Slow tick
	input wire boot_load, // Factory load strobe
	input wire [7:0] factory_fast_trim, // Factory fast value
	input wire [7:0] factory_slow_trim, // Factory slow value
	input wire cpu_clock, // CPU enable
	input wire usb_engine_clock, // USB enable
	input wire capture_timer_clock, // Capture enable
	input wire wakeup_tick, // Wakeup pulse
	input wire [2:0] fast_offset, // Fine offset
	input wire [4:0] fast_gain, // Gain
	input wire [7:0] fast_tune, // Retune value
	input wire slow_low_power, // Mode bit
	input wire [1:0] slow_bias, // Bias
	input wire [3:0] slow_freq_trim // Frequency trim
);
	// Completed trim writes; a boot strobe in the same cycle wins
	wire wr_done = psel && penable && pready && pwrite;
	wire fast_wr = wr_done && paddr == {`CSOT_IDX_FAST_TRIM, 2'b00} && !boot_load;
	wire slow_wr = wr_done && paddr == {`CSOT_IDX_SLOW_TRIM, 2'b00} && !boot_load;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
		else $error("pready not after one wait cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_fast_write: assert property (fast_wr |=>
		fast_offset == $past(pwdata[7:5]) && fast_gain == $past(pwdata[4:0]))
		else $error("fast trim fields not written");
	a_slow_write: assert property (slow_wr |=>
		slow_low_power == $past(pwdata[7]) && slow_freq_trim == $past(pwdata[3:0]))
		else $error("slow trim fields not written");
	a_bias_refused: assert property (slow_wr && pwdata[5:4] == 2'b10 |=> $stable(slow_bias))
		else $error("reserved bias code applied");
	a_bias_never: assert property (slow_bias != 2'b10)
		else $error("bias shows reserved code");
	a_boot_load: assert property (boot_load |=> fast_offset == $past(factory_fast_trim[7:5])
		&& fast_gain == $past(factory_fast_trim[4:0])
		&& slow_freq_trim == $past(factory_slow_trim[3:0]))
		else $error("factory trims not loaded");
	a_cpu_source: assert property (cpu_clock |-> $past(fast_osc_tick, 2))
		else $error("cpu enable without fast tick");
	a_usb_source: assert property (usb_engine_clock |-> $past(fast_osc_tick, 2))
		else $error("usb enable without fast tick");
	a_cap_source: assert property (capture_timer_clock |->
		$past(fast_osc_tick, 2) || $past(slow_osc_tick, 2))
		else $error("capture enable without source tick");
	a_tune_reset: assert property ($rose(presetn) |-> fast_tune == 8'h80)
		else $error("retune value not mid-scale after reset");
	a_tune_step: assert property (fast_tune != $past(fast_tune) |->
		fast_tune == $past(fast_tune) + 8'h01 || fast_tune == $past(fast_tune) - 8'h01)
		else $error("retune moved by more than one");

	c_boot: cover property (boot_load);
	c_bias_bad: cover property (slow_wr && pwdata[5:4] == 2'b10);
	c_err: cover property (pslverr);
	c_wake: cover property (wakeup_tick);
endmodule // csot_chk

bind csot_top csot_chk csot_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .pslverr, .fast_osc_tick, .slow_osc_tick, .boot_load, .factory_fast_trim,
	.factory_slow_trim, .cpu_clock, .usb_engine_clock, .capture_timer_clock, .wakeup_tick,
	.fast_offset, .fast_gain, .fast_tune, .slow_low_power, .slow_bias, .slow_freq_trim);

/* bench/testbench.sv */
/*
 Self-checking bench for csot_top: APB register checks, enable pulse counts,
 table read and retune. Assumes csot_consts.vh on the include path.
*/
`timescale 1ns/100ps
`include "csot_consts.vh"
module testbench;
	localparam [15:0] ID = 16'h2b71; // Arbitrary identifier value
	localparam [9:0] FT = `CSOT_IDX_FAST_TRIM;
	localparam [9:0] ST = `CSOT_IDX_SLOW_TRIM;
	localparam [9:0] OC = `CSOT_IDX_OSC_CTRL;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	wire [31:0] prdata;
	wire pready, pslverr, cpu_clock, usb_engine_clock, interval_timer_clock;
	wire capture_timer_clock, clock_output_pin, wakeup_tick, slow_low_power;
	logic fast_osc_tick = 1, slow_osc_tick = 0, external_clock_input = 0;
	logic sleep = 0, usb_mark = 0, boot_load = 0, rnd = 0, pin_q = 0;
	logic [7:0] factory_fast_trim = 0, factory_slow_trim = 0, r8, t8;
	wire [2:0] fast_offset;
	wire [4:0] fast_gain;
	wire [7:0] fast_tune;
	wire [1:0] slow_bias;
	wire [3:0] slow_freq_trim;
	logic [1:0] sb;
	integer seed = 32'he470;
	int num_errors = 0, n_compared = 0, ph = 0, cnt[6] = '{0, 0, 0, 0, 0, 0}, dv[6];
	logic [32:0] q[$];
	int ex[7] = '{3, 2, 1, 0, 4, 5, 7};
	logic [7:0] tc[8] = '{8'h00, 8'h4c, 8'h83, 8'hc7, 8'h08, 8'h22, 8'h22, 8'h30};
	bit tsl[8] = '{0, 0, 0, 0, 0, 0, 1, 0};
	int tcap[8] = '{192, 96, 64, 48, 192, 48, 0, 0};
	int titm[8] = '{384, 96, 64, 24, 128, 96, 0, 384};
	logic [7:0] rt[5] = '{8'h01, 8'h06, 8'h06, 8'h03, 8'h08};
	bit rsl[5] = '{0, 0, 1, 0, 0};
	int rpin[5] = '{384, 96, 0, 3, 24};
	int rusb[5] = '{384, 192, 192, 384, 384};

	csot_top #(.CHIP_ID(ID), .TUNE_REF(16'd20), .TUNE_TOL(16'd2)) csot_top_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fast_osc_tick,
		.slow_osc_tick, .external_clock_input, .sleep, .usb_mark, .boot_load,
		.factory_fast_trim, .factory_slow_trim, .cpu_clock, .usb_engine_clock,
		.interval_timer_clock, .capture_timer_clock, .clock_output_pin, .wakeup_tick,
		.fast_offset, .fast_gain, .fast_tune, .slow_low_power, .slow_bias, .slow_freq_trim);

	initial forever #50 pclk = ~pclk;

	// Oscillator ticks; fast is steady during counts so totals are exact
	always @(posedge pclk) begin
		ph <= ph + 1;
		slow_osc_tick <= (ph % 4 == 3);
		fast_osc_tick <= rnd ? ph[0] ^ ph[2] : 1'b1;
		if (ph % 8 == 7)
			external_clock_input <= ~external_clock_input;
	end

	// Pulse counters on the falling edge, away from output updates
	always @(negedge pclk) begin
		cnt[0] += cpu_clock;
		cnt[1] += usb_engine_clock;
		cnt[2] += interval_timer_clock;
		cnt[3] += capture_timer_clock;
		cnt[4] += (clock_output_pin !== pin_q);
		cnt[5] += wakeup_tick;
		pin_q = clock_output_pin;
	end

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Read results are noted when issued and compared when pready comes
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, q.pop_front());
	end

	// One APB transfer; entered just after a rising edge, leaves one idle cycle
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
		input logic [32:0] e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		if (!w)
			q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
			num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h0);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b0, idx, 8'h00, {25'h0, d});
	endtask

	task automatic meas(input int n);
		int s[6];
		s = cnt;
		repeat (n) @(posedge pclk);
		foreach (dv[i]) dv[i] = cnt[i] - s[i];
	endtask

	task automatic marks(input int gap, input int n);
		repeat (n) begin
			repeat (gap) @(posedge pclk);
			usb_mark <= 1'b1;
			@(posedge pclk);
			usb_mark <= 1'b0;
		end
		repeat (3) @(posedge pclk);
	endtask

	function automatic [9:0] pb(input int i);
		pb = {`CSOT_IDX_PBLK, i[2:0]};
	endfunction

	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog sized well above the roughly 15k cycles of the tests
	initial begin
		#3000000;
		num_errors++;
		tally_and_finish;
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`CSOT_IDX_TMR_CFG, `CSOT_TMR_CFG_RST);
		rd(`CSOT_IDX_ROUTE, `CSOT_ROUTE_RST);
		rd(OC, `CSOT_OSC_CTRL_RST);
		rd(`CSOT_IDX_USB_LOCK, 8'h00);
		apb(1'b0, 10'h001, 8'h00, {1'b1, 32'h0});
		$display("test reset_values done");
		// Boot strobe with a legal bias, then random trim traffic
		rnd <= 1'b1;
		factory_fast_trim <= $random(seed);
		factory_slow_trim <= $random(seed) & 8'hdf;
		boot_load <= 1'b1;
		@(posedge pclk);
		boot_load <= 1'b0;
		@(posedge pclk);
		rd(FT, factory_fast_trim);
		rd(ST, factory_slow_trim & `CSOT_SLOW_RW_MASK);
		sb = factory_slow_trim[5:4];
		for (int i = 0; i < 4; i++) begin
			r8 = $random(seed);
			wr(FT, r8);
			rd(FT, r8);
			t8 = $random(seed);
			if (i == 1)
				t8[5:4] = `CSOT_BIAS_BAD;
			wr(ST, t8);
			if (t8[5:4] != `CSOT_BIAS_BAD)
				sb = t8[5:4];
			rd(ST, {t8[7], 1'b0, sb, t8[3:0]});
		end
		// Mode bit flipped by read-modify-write, calibration kept
		wr(ST, {~t8[7], 1'b0, sb, t8[3:0]});
		rd(ST, {~t8[7], 1'b0, sb, t8[3:0]});
		rnd <= 1'b0;
		$display("test trims done");
		for (int c = 0; c < 7; c++) begin
			wr(OC, c[7:0]);
			sleep <= c[0];
			meas(384);
			meas(256);
			chk(dv[0], 256 >> ex[c]);
			chk(dv[1], 128);
			chk(dv[5], 1);
		end
		wr(OC, 8'h07);
		rd(OC, 8'h06);
		$display("test cpu_speed done");
		for (int k = 0; k < 8; k++) begin
			wr(`CSOT_IDX_TMR_CFG, tc[k]);
			sleep <= tsl[k];
			meas(384);
			meas(384);
			chk(dv[3], tcap[k]);
			chk(dv[2], titm[k]);
		end
		$display("test timers done");
		for (int k = 0; k < 5; k++) begin
			wr(`CSOT_IDX_ROUTE, rt[k]);
			sleep <= rsl[k];
			meas(384);
			meas(384);
			chk(dv[4], rpin[k]);
			chk(dv[1], rusb[k]);
		end
		sleep <= 1'b0;
		$display("test clock_pin done");
		// Table 0 returns the identifier, other tables leave the block alone
		wr(pb(0), `CSOT_KEY_TBL);
		wr(pb(1), 8'h23); // Stack pointer plus three
		wr(pb(2), `CSOT_TBL_ID);
		wr(`CSOT_IDX_TBL_CMD, `CSOT_OP_TBL);
		rd(pb(0), ID[15:8]);
		rd(pb(1), ID[7:0]);
		wr(pb(0), `CSOT_KEY_TBL);
		wr(pb(2), 8'h01);
		wr(`CSOT_IDX_TBL_CMD, `CSOT_OP_TBL);
		rd(pb(0), `CSOT_KEY_TBL);
		rd(pb(7), 8'h00);
		$display("test table_read done");
		// Slow marks pull the trim down, fast marks push it up
		marks(30, 4);
		chk(fast_tune < 8'h80, 1'b1);
		r8 = fast_tune;
		marks(12, 8);
		chk(fast_tune > r8, 1'b1);
		wr(`CSOT_IDX_USB_LOCK, 8'h01);
		rd(`CSOT_IDX_USB_LOCK, 8'h01);
		r8 = fast_tune;
		marks(30, 4);
		chk(fast_tune, r8);
		// Status read twice, both readings must agree
		rd(`CSOT_IDX_STATUS, r8);
		rd(`CSOT_IDX_STATUS, r8);
		$display("test retune done");
		tally_and_finish;
	end
endmodule // testbench
